// *** logic/evq_top.sv ***
// event qualification, interrupt flags and sync status of a 12-bit timer
// assumes a strobe register port; waveform outputs and strobes come from the timer
// Functional notes
// - filtered event changes only after four equal consecutive samples
// - filtering delays event capture by four clock cycles
// - async qualification lets the event act on outputs directly
// - config bits 7:6: 0 none, 1 filter, 2 async, others reserved
// - polarity bit 4: falling/low when clear, rising/high when set
// - action bit 2: fault only when clear, fault and capture when set
// - event fault follows the timer input-mode setting
// - bit 0 of config A enables event as trigger for input A
// - bit 0 of config B enables event as trigger for input B
// - enable bits 3 and 2 allow trigger B and trigger A interrupts
// - enable bit 0 allows the cycle-end interrupt
// - trigger or capture on B/A sets flag bit 3/2
// - flag bit 0 sets at each cycle end
// - flags clear only by writing one; zero leaves them
// - activity bit 7/6 sets on any level change of output B/A
// - activity bits clear by writing one before reporting again
// - command-ready bit 1 high when last command reached timer domain
// - command strobes or compare B high write with auto-update drop command-ready
// - enable-ready bit 0 high once enable reached timer domain
// - enable write, disable-at-end strobe or debug break without debug-run drop enable-ready
// - command strobes during a pending sync are ignored
//
// Decided for this implementation: the plain strobed port.
module evq_top
    import evq_pkg::*;
(
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // event inputs from the routing network
    input  wire logic       EVENT_A,
    input  wire logic       EVENT_B,
    // timer side inputs
    input  wire logic       WAVEFORM_OUT_A,
    input  wire logic       WAVEFORM_OUT_B,
    input  wire logic       CYCLE_END,
    input  wire logic       CMD_STROBE,
    input  wire logic       AUTO_UPDATE,
    input  wire logic       COMPARE_B_CLEAR_HIGH_WR,
    input  wire logic       ENABLE_WR,
    input  wire logic       DISABLE_AT_CYCLE_END_STROBE,
    input  wire logic       DEBUG_BREAK,
    input  wire logic       DEBUG_RUN,
    // qualified events towards the timer
    output logic            FAULT_A,
    output logic            FAULT_B,
    output logic            CAPTURE_A,
    output logic            CAPTURE_B,
    output logic            ASYNC_FAULT_A,
    output logic            ASYNC_FAULT_B,
    output logic            COMMAND_ACCEPTED,
    // interrupt requests
    output logic            IRQ_TRIG_A,
    output logic            IRQ_TRIG_B,
    output logic            IRQ_CYCLE_END
);
    logic [7:0] ev_a_cfg;
    logic [7:0] ev_b_cfg;
    logic [7:0] irq_en;
    logic [7:0] irq_flag;
    logic [7:0] act_flag;
    logic [7:0] next_irq_flag;
    logic [7:0] next_act_flag;
    logic [7:0] status;
    logic [2:0] wo_a_s;
    logic [2:0] wo_b_s;
    ev_out_t    res_a;
    ev_out_t    res_b;
    logic       async_a;
    logic       async_b;
    logic       cmd_ready;
    logic       cmd_acc;
    logic       en_ready;
    logic       debug_break_q;
    logic       cmd_start;
    logic       en_start;
    logic       wr_flag;
    logic       wr_status;
    logic       set_a;
    logic       set_b;
    logic       set_ovf;
    logic       wo_a_chg;
    logic       wo_b_chg;

    // per-input qualification
    evq_filter #(.LEN(FILTER_LEN)) u_ev_a (
        .clk          (CLK),
        .rst          (RST),
        .ev_raw       (EVENT_A),
        .ctrl         (unpack_ev(ev_a_cfg)),
        .res          (res_a),
        .async_active (async_a)
    );

    evq_filter #(.LEN(FILTER_LEN)) u_ev_b (
        .clk          (CLK),
        .rst          (RST),
        .ev_raw       (EVENT_B),
        .ctrl         (unpack_ev(ev_b_cfg)),
        .res          (res_b),
        .async_active (async_b)
    );

    // command strobes and auto-update compare write both start a command sync
    assign cmd_start = CMD_STROBE || (AUTO_UPDATE && COMPARE_B_CLEAR_HIGH_WR);

    evq_sync #(.LAT(SYNC_CYCLES)) u_cmd (
        .clk      (CLK),
        .rst      (RST),
        .start    (cmd_start),
        .hold     (1'b0),
        .ready    (cmd_ready),
        .accepted (cmd_acc)
    );

    // a debug break without debug-run freezes the enable transfer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            debug_break_q <= 1'b0;
        end else begin
            debug_break_q <= DEBUG_BREAK && !DEBUG_RUN;
        end
    end

    assign en_start = ENABLE_WR || DISABLE_AT_CYCLE_END_STROBE ||
                      (DEBUG_BREAK && !DEBUG_RUN && !debug_break_q);

    evq_sync #(.LAT(SYNC_CYCLES)) u_en (
        .clk      (CLK),
        .rst      (RST),
        .start    (en_start),
        .hold     (DEBUG_BREAK && !DEBUG_RUN),
        .ready    (en_ready),
        .accepted ()
    );

    // waveform outputs arrive from a separate clock, so three stages
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wo_a_s <= 3'h0;
            wo_b_s <= 3'h0;
        end else begin
            wo_a_s <= {wo_a_s[1:0], WAVEFORM_OUT_A};
            wo_b_s <= {wo_b_s[1:0], WAVEFORM_OUT_B};
        end
    end

    assign wo_a_chg = wo_a_s[2] != wo_a_s[1];
    assign wo_b_chg = wo_b_s[2] != wo_b_s[1];

    // hardware set conditions
    assign set_a   = res_a.trigger || res_a.capture;
    assign set_b   = res_b.trigger || res_b.capture;
    assign set_ovf = CYCLE_END;

    assign wr_flag   = WR && ADDR == OFF_IFLAG;
    assign wr_status = WR && ADDR == OFF_STATUS;

    // write-one-to-clear, then set so a same-cycle event survives
    always_comb begin
        next_irq_flag = irq_flag;
        if (wr_flag) begin
            next_irq_flag = irq_flag & ~(WDATA & IRQ_MASK);
        end
        if (set_a) next_irq_flag[IRQ_A_BIT] = 1'b1;
        if (set_b) next_irq_flag[IRQ_B_BIT] = 1'b1;
        if (set_ovf) next_irq_flag[IRQ_OVF_BIT] = 1'b1;
    end

    always_comb begin
        next_act_flag = act_flag;
        if (wr_status) begin
            next_act_flag = act_flag & ~(WDATA & ACT_MASK);
        end
        if (wo_a_chg) next_act_flag[ACT_A_BIT] = 1'b1;
        if (wo_b_chg) next_act_flag[ACT_B_BIT] = 1'b1;
    end

    // control registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ev_a_cfg <= REG_RESET;
            ev_b_cfg <= REG_RESET;
            irq_en   <= REG_RESET;
        end else if (WR) begin
            if (ADDR == OFF_EVA) ev_a_cfg <= WDATA & EV_MASK;
            if (ADDR == OFF_EVB) ev_b_cfg <= WDATA & EV_MASK;
            if (ADDR == OFF_IEN) irq_en <= WDATA & IRQ_MASK;
        end
    end

    // sticky flags
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_flag <= REG_RESET;
            act_flag <= REG_RESET;
        end else begin
            irq_flag <= next_irq_flag;
            act_flag <= next_act_flag;
        end
    end

    always_comb begin
        status          = act_flag;
        status[CMD_BIT] = cmd_ready;
        status[EN_BIT]  = en_ready;
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= REG_RESET;
        end else if (RD) begin
            unique case (ADDR)
                OFF_EVA:    RDATA <= ev_a_cfg;
                OFF_EVB:    RDATA <= ev_b_cfg;
                OFF_IEN:    RDATA <= irq_en;
                OFF_IFLAG:  RDATA <= irq_flag;
                OFF_STATUS: RDATA <= status;
                default:    RDATA <= REG_RESET;
            endcase
        end else begin
            RDATA <= REG_RESET;
        end
    end

    // outputs towards the timer, registered so they change on clean edges
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            FAULT_A   <= 1'b0;
            FAULT_B   <= 1'b0;
            CAPTURE_A <= 1'b0;
            CAPTURE_B <= 1'b0;
        end else begin
            FAULT_A   <= res_a.fault;
            FAULT_B   <= res_b.fault;
            CAPTURE_A <= res_a.capture;
            CAPTURE_B <= res_b.capture;
        end
    end

    // unregistered on purpose: async qualification must not wait for a clock
    assign ASYNC_FAULT_A    = async_a;
    assign ASYNC_FAULT_B    = async_b;
    assign COMMAND_ACCEPTED = cmd_acc;

    // interrupt request lines, enable gating of the sticky flags
    assign IRQ_TRIG_A    = irq_flag[IRQ_A_BIT] && irq_en[IRQ_A_BIT];
    assign IRQ_TRIG_B    = irq_flag[IRQ_B_BIT] && irq_en[IRQ_B_BIT];
    assign IRQ_CYCLE_END = irq_flag[IRQ_OVF_BIT] && irq_en[IRQ_OVF_BIT];

    chk_set_wins : assert property (@(posedge CLK) disable iff (RST)
        (set_a && wr_flag && WDATA[IRQ_A_BIT]) |=> irq_flag[IRQ_A_BIT])
        else $error("trigger A flag lost to same-cycle clear");
    chk_flag_w0 : assert property (@(posedge CLK) disable iff (RST)
        (wr_flag && !WDATA[IRQ_OVF_BIT] && irq_flag[IRQ_OVF_BIT]) |=> irq_flag[IRQ_OVF_BIT])
        else $error("overflow flag cleared by zero write");
    chk_flag_w1 : assert property (@(posedge CLK) disable iff (RST)
        (wr_flag && WDATA[IRQ_B_BIT] && !set_b) |=> !irq_flag[IRQ_B_BIT])
        else $error("trigger B flag not cleared by one write");
    chk_ovf_set : assert property (@(posedge CLK) disable iff (RST)
        CYCLE_END |=> irq_flag[IRQ_OVF_BIT])
        else $error("overflow flag not set at cycle end");
    chk_trig_set : assert property (@(posedge CLK) disable iff (RST)
        res_b.trigger |=> irq_flag[IRQ_B_BIT])
        else $error("trigger B flag not set");
    chk_act_set : assert property (@(posedge CLK) disable iff (RST)
        $changed(wo_a_s[2]) |-> act_flag[ACT_A_BIT])
        else $error("output A activity not reported");
    chk_act_clear : assert property (@(posedge CLK) disable iff (RST)
        (wr_status && WDATA[ACT_B_BIT] && !wo_b_chg) |=> !act_flag[ACT_B_BIT])
        else $error("output B activity not cleared");
    chk_cmd_ready : assert property (@(posedge CLK) disable iff (RST)
        (AUTO_UPDATE && COMPARE_B_CLEAR_HIGH_WR && cmd_ready) |=> !status[CMD_BIT])
        else $error("command ready did not drop on compare write");
    chk_cmd_back : assert property (@(posedge CLK) disable iff (RST)
        (cmd_acc ##1 !cmd_start [*5]) |-> cmd_ready)
        else $error("command ready did not return");
    chk_en_drop : assert property (@(posedge CLK) disable iff (RST)
        (ENABLE_WR && en_ready) |=> !status[EN_BIT] [*2])
        else $error("enable ready did not drop");
    chk_irq_gate : assert property (@(posedge CLK) disable iff (RST)
        IRQ_CYCLE_END |-> irq_en[IRQ_OVF_BIT])
        else $error("overflow request without enable");
    chk_rsvd_zero : assert property (@(posedge CLK) disable iff (RST)
        (RD && ADDR == OFF_IEN) |=> (RDATA & ~IRQ_MASK) == 8'h00)
        else $error("reserved interrupt enable bits read nonzero");
endmodule

// *** logic/evq_pkg.sv ***
// shared constants and carriers for the event qualification and status block
// assumes a single 100 MHz clock domain and a plain strobe register port
package evq_pkg;
    // register offsets
    localparam logic [7:0] OFF_EVA    = 8'h08;
    localparam logic [7:0] OFF_EVB    = 8'h09;
    localparam logic [7:0] OFF_IEN    = 8'h0C;
    localparam logic [7:0] OFF_IFLAG  = 8'h0D;
    localparam logic [7:0] OFF_STATUS = 8'h0E;
    localparam logic [7:0] REG_RESET  = 8'h00;
    // event config field positions
    localparam int CFG_HI    = 7;
    localparam int CFG_LO    = 6;
    localparam int POL_BIT   = 4;
    localparam int ACT_BIT   = 2;
    localparam int TRIG_BIT  = 0;
    localparam logic [7:0] EV_MASK = 8'hD5;
    // interrupt bits
    localparam int IRQ_B_BIT   = 3;
    localparam int IRQ_A_BIT   = 2;
    localparam int IRQ_OVF_BIT = 0;
    localparam logic [7:0] IRQ_MASK = 8'h0D;
    // status bits
    localparam int ACT_B_BIT  = 7;
    localparam int ACT_A_BIT  = 6;
    localparam int CMD_BIT    = 1;
    localparam int EN_BIT     = 0;
    localparam logic [7:0] ACT_MASK = 8'hC0;
    // filter length in samples
    localparam int FILTER_LEN = 4;
    // sync latency into the timer domain, in bus cycles
    localparam int SYNC_CYCLES = 3;

    typedef enum logic [1:0] {
        CFG_NEITHER = 2'b00,
        CFG_FILTER  = 2'b01,
        CFG_ASYNC   = 2'b10,
        CFG_RSVD    = 2'b11
    } ev_cfg_t;

    typedef struct packed {
        ev_cfg_t cfg;
        logic    rise_high;
        logic    capture;
        logic    trig_en;
    } ev_ctrl_t;

    typedef struct packed {
        logic fault;
        logic capture;
        logic trigger;
    } ev_out_t;

    function automatic ev_ctrl_t unpack_ev(input logic [7:0] r);
        ev_ctrl_t c;
        c.cfg       = ev_cfg_t'(r[CFG_HI:CFG_LO]);
        c.rise_high = r[POL_BIT];
        c.capture   = r[ACT_BIT];
        c.trig_en   = r[TRIG_BIT];
        return c;
    endfunction
endpackage

// *** logic/evq_filter.sv ***
// one event input: synchroniser, optional four-sample filter, polarity, action
// assumes the raw event comes from outside the clock domain
module evq_filter
    import evq_pkg::*;
#(
    parameter int LEN = FILTER_LEN
) (
    // clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // raw event and its setup
    input  wire logic     ev_raw,
    input  wire ev_ctrl_t ctrl,
    // qualified results
    output ev_out_t       res,
    output logic          async_active
);
    initial begin
        if (LEN < 2 || LEN > 8) $error("evq_filter: LEN out of range");
    end

    logic [2:0]     sync;
    logic [LEN-1:0] hist;
    logic           filt;
    logic           filt_now;
    logic           level_q;
    logic           level;
    logic           active;
    logic           edge_hit;

    // three-stage synchroniser; only stages two and three are looked at
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync <= 3'h0;
        end else begin
            sync <= {sync[1:0], ev_raw};
        end
    end

    // history of agreed samples feeding the filter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hist <= '0;
        end else if (sync[2] == sync[1]) begin
            hist <= {hist[LEN-2:0], sync[2]};
        end
    end

    // filtered level moves only when all samples agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt <= 1'b0;
        end else if (&hist) begin
            filt <= 1'b1;
        end else if (~|hist) begin
            filt <= 1'b0;
        end
    end

    // the agreeing history is looked at directly, so the filter adds exactly
    // its length in cycles and no extra register stage
    assign filt_now = (&hist) ? 1'b1 : ((~|hist) ? 1'b0 : filt);
    assign level    = (ctrl.cfg == CFG_FILTER) ? filt_now : sync[2];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level;
        end
    end

    // polarity picks the active edge for capture and the active level for fault
    assign active   = ctrl.rise_high ? level : ~level;
    assign edge_hit = ctrl.rise_high ? (level & ~level_q) : (~level & level_q);

    // reserved config codes leave the input without effect
    always_comb begin
        res.fault   = ctrl.trig_en && ctrl.cfg != CFG_RSVD && active;
        res.trigger = ctrl.trig_en && ctrl.cfg != CFG_RSVD && edge_hit;
        res.capture = res.trigger && ctrl.capture;
    end

    // asynchronous qualification bypasses every flip-flop
    assign async_active = ctrl.trig_en && ctrl.cfg == CFG_ASYNC &&
                          (ev_raw == ctrl.rise_high);

    chk_filter_hold : assert property (@(posedge clk) disable iff (rst)
        (ctrl.cfg == CFG_FILTER && !(&hist) && !(~|hist)) |=> $stable(filt))
        else $error("filter output moved without agreeing samples");
    chk_capture_gate : assert property (@(posedge clk) disable iff (rst)
        res.capture |-> (ctrl.capture && res.trigger))
        else $error("capture without capture action");
endmodule

// *** logic/evq_sync.sv ***
// ready flag of a bus to timer domain transfer
// assumes start pulses arrive on the bus clock; ready returns LAT+1 cycles after the accepting edge
module evq_sync
    import evq_pkg::*;
#(
    parameter int LAT = SYNC_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // transfer start and hold-off
    input  wire logic start,
    input  wire logic hold,
    // ready state
    output logic      ready,
    output logic      accepted
);
    initial begin
        if (LAT < 1 || LAT > 255) $error("evq_sync: LAT out of range");
    end

    logic [7:0] cnt;
    logic       busy;

    // a start while a transfer is pending is dropped
    assign accepted = start && !busy;

    // countdown stands in for the round trip through the timer domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= 8'h00;
            busy <= 1'b0;
        end else if (accepted) begin
            cnt  <= 8'(LAT);
            busy <= 1'b1;
        end else if (busy && !hold && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else if (busy && !hold) begin
            busy <= 1'b0;
        end
    end

    assign ready = !busy;

    chk_ready_drop : assert property (@(posedge clk) disable iff (rst)
        accepted |=> !ready [*3])
        else $error("ready did not drop after start");
endmodule

// *** verification/evq_far.sv ***
// far side model: event routing network and timer waveform source
// assumes the bench sets requests right after a rising edge
module evq_far
(
    // clock
    input  wire logic       clk,
    // requested levels and pulses
    input  wire logic [4:0] req,
    // driven towards the block: cycle end, waveform b/a, event b/a
    output logic      [4:0] drv = 5'h00
);
    timeunit 1ns;
    timeprecision 1ns;

    // the network only moves on a clock edge, so no level changes between edges
    always @(posedge clk) begin
        drv <= req;
    end
endmodule

// *** verification/pwm_timer_event_irq_status_tb_top.sv ***
// self-checking bench of the event qualification and status block
// assumes evq_far supplies events, waveform levels and cycle-end pulses
module pwm_timer_event_irq_status_tb_top
    import evq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, aup = 1'b0;
    logic       brk = 1'b0, drun = 1'b0, acc;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, d;
    logic [4:0] req = 5'h00, fd;
    logic [3:0] sy = 4'h0;
    logic [1:0] flt, cap, af;
    logic [2:0] irq;
    int         fail_count = 0, checked = 0, n;
    int         seed = int'(32'ha716_42ac);
    logic [7:0] offs [5] = '{OFF_EVA, OFF_EVB, OFF_IEN, OFF_IFLAG, OFF_STATUS};
    logic [7:0] msk [3] = '{EV_MASK, EV_MASK, IRQ_MASK};
    logic [7:0] neg_cfg [3] = '{8'h14, 8'hD5, 8'h55};
    int         neg_w [3] = '{10, 10, 2};
    logic [7:0] acfg [2] = '{8'h91, 8'h15};
    int         sy_idx [5] = '{0, 1, 1, 2, 3};
    logic [7:0] sy_exp [5] = '{8'h01, 8'h01, 8'h03, 8'h02, 8'h02};

    // 100 MHz clock
    always #5 clk = ~clk;

    evq_far far (.clk(clk), .req(req), .drv(fd));

    evq_top uut (
        .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .EVENT_A(fd[0]), .EVENT_B(fd[1]), .WAVEFORM_OUT_A(fd[2]), .WAVEFORM_OUT_B(fd[3]),
        .CYCLE_END(fd[4]), .CMD_STROBE(sy[0]), .AUTO_UPDATE(aup),
        .COMPARE_B_CLEAR_HIGH_WR(sy[1]), .ENABLE_WR(sy[2]),
        .DISABLE_AT_CYCLE_END_STROBE(sy[3]), .DEBUG_BREAK(brk), .DEBUG_RUN(drun),
        .FAULT_A(flt[0]), .FAULT_B(flt[1]), .CAPTURE_A(cap[0]), .CAPTURE_B(cap[1]),
        .ASYNC_FAULT_A(af[0]), .ASYNC_FAULT_B(af[1]), .COMMAND_ACCEPTED(acc),
        .IRQ_TRIG_A(irq[0]), .IRQ_TRIG_B(irq[1]), .IRQ_CYCLE_END(irq[2])
    );

    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wreg(input logic [7:0] a, input logic [7:0] val);
        @(posedge clk);
        addr <= a;
        wdata <= val;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // count capture pulses over a quiet stretch
    task automatic quiet(input int s, output int k);
        k = 0;
        repeat (16) begin
            @(posedge clk);
            #1 if (cap[s] !== 1'b0) k++;
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        cyc(12);
        rst <= 1'b0;
        foreach (offs[i]) rchk(offs[i], i == 4 ? 8'h03 : 8'h00);
        // random values only keep the implemented bits
        repeat (4) begin
            foreach (msk[i]) begin
                v = 8'($random(seed));
                wreg(offs[i], v);
                rchk(offs[i], v & msk[i]);
            end
        end
        wreg(8'h0A, 8'hFF);
        rchk(8'h0A, 8'h00);
        foreach (msk[i]) wreg(offs[i], 8'h00);
        wreg(OFF_IFLAG, IRQ_MASK);
        rchk(OFF_IFLAG, 8'h00);
        $display("done: registers");
        // cycle end flag, its enable, and a zero write that must not clear
        @(posedge clk);
        req[4] <= 1'b1;
        @(posedge clk);
        req[4] <= 1'b0;
        cyc(2);
        rchk(OFF_IFLAG, 8'h01);
        chk(8'(irq[2]), 8'h00);
        wreg(OFF_IEN, 8'h01);
        #1 chk(8'(irq[2]), 8'h01);
        wreg(OFF_IFLAG, 8'h0C);
        rchk(OFF_IFLAG, 8'h01);
        wreg(OFF_IFLAG, 8'h01);
        rchk(OFF_IFLAG, 8'h00);
        $display("done: cycle end");
        // rising capture on both inputs, unfiltered then filtered
        for (int s = 0; s < 2; s++) begin
            for (int f = 0; f < 2; f++) begin
                wreg(OFF_EVA + 8'(s), f ? 8'h55 : 8'h15);
                wreg(OFF_IFLAG, IRQ_MASK);
                @(posedge clk);
                req[s] <= 1'b1;
                @(posedge clk);
                n = 0;
                while (cap[s] !== 1'b1 && n < 20) begin
                    @(posedge clk);
                    n++;
                    #1;
                end
                chk(8'(n), 8'(4 + f * FILTER_LEN));
                rchk(OFF_IFLAG, 8'(4 << s));
                chk(8'(flt[s]), 8'h01);
                wreg(OFF_IEN, IRQ_MASK);
                #1 chk(8'(irq[s]), 8'h01);
                wreg(OFF_IEN, 8'h00);
                @(posedge clk);
                req[s] <= 1'b0;
                cyc(14);
                #1 chk(8'(flt[s]), 8'h00);
            end
        end
        wreg(OFF_EVB, 8'h00);
        $display("done: capture");
        // disabled, reserved code, and a glitch shorter than the filter
        foreach (neg_cfg[i]) begin
            wreg(OFF_EVA, neg_cfg[i]);
            wreg(OFF_IFLAG, IRQ_MASK);
            @(posedge clk);
            req[0] <= 1'b1;
            cyc(neg_w[i]);
            req[0] <= 1'b0;
            #1 chk(8'(flt[0]), 8'h00);
            quiet(0, n);
            chk(8'(n), 8'h00);
            rchk(OFF_IFLAG, 8'h00);
        end
        $display("done: refused events");
        // falling/low polarity with fault only: low level faults, no capture
        wreg(OFF_EVA, 8'h01);
        cyc(8);
        #1 chk(8'(flt[0]), 8'h01);
        @(posedge clk);
        req[0] <= 1'b1;
        cyc(8);
        #1 chk(8'(flt[0]), 8'h00);
        @(posedge clk);
        req[0] <= 1'b0;
        quiet(0, n);
        chk(8'(n), 8'h00);
        $display("done: polarity and action");
        // async path reacts before the synchroniser can have seen the event
        foreach (acfg[i]) begin
            wreg(OFF_EVA, acfg[i]);
            @(posedge clk);
            req[0] <= 1'b1;
            @(posedge clk);
            #1 chk(8'(af[0]), 8'(i == 0));
            chk(8'(af[1]), 8'h00);
            @(posedge clk);
            req[0] <= 1'b0;
            cyc(10);
        end
        wreg(OFF_EVA, 8'h00);
        $display("done: async");
        // waveform activity stays until written with one
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            req[2 + s] <= 1'b1;
            cyc(8);
            rchk(OFF_STATUS, 8'h03 | 8'(8'h40 << s));
            @(posedge clk);
            req[2 + s] <= 1'b0;
            wreg(OFF_STATUS, 8'h00);
            rchk(OFF_STATUS, 8'h03 | 8'(8'h40 << s));
            wreg(OFF_STATUS, 8'hC0);
            rchk(OFF_STATUS, 8'h03);
        end
        $display("done: activity");
        // ready bits: start, refusal while busy, return after five cycles
        foreach (sy_idx[i]) begin
            @(posedge clk);
            aup <= (i == 1);
            sy[sy_idx[i]] <= 1'b1;
            #1 chk(8'(acc), 8'(sy_exp[i] == 8'h01));
            @(posedge clk);
            #1 chk(8'(acc), 8'h00);
            @(posedge clk);
            sy[sy_idx[i]] <= 1'b0;
            rchk(OFF_STATUS, sy_exp[i]);
            rchk(OFF_STATUS, 8'h03);
        end
        // a break holds enable-ready low only without debug-run
        for (int r = 1; r >= 0; r--) begin
            @(posedge clk);
            drun <= 1'(r);
            brk <= 1'b1;
            cyc(10);
            rchk(OFF_STATUS, r ? 8'h03 : 8'h02);
            @(posedge clk);
            brk <= 1'b0;
            cyc(10);
        end
        rchk(OFF_STATUS, 8'h03);
        $display("done: sync status");
        results();
    end

    // hang guard: the whole run needs well under 40 us
    initial begin
        #100000;
        fail_count++;
        results();
    end
endmodule
